// File: logic/spu_framer.sv
// Word length and frame synchronisation of one serial port unit.
// Assumes register writes on the data memory port and words on tx/rx strobes.
`timescale 1ns/100ps
`include "spu_map.svh"
module spu_framer #(
  parameter bit PORT_ONE = 1'b0
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [13:0] dm_addr,
  input wire logic [15:0] dm_wdata,
  input wire logic dm_wr,
  input wire logic dm_rd,
  output logic [15:0] dm_rdata,
  input wire logic bclk_i,
  output logic bclk_o,
  output logic bclk_oe,
  input wire logic rx_frame_sync_i,
  output logic rx_frame_sync_o,
  output logic rx_frame_sync_oe,
  input wire logic tx_frame_sync_i,
  output logic tx_frame_sync_o,
  output logic tx_frame_sync_oe,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  input wire logic [15:0] tx_word,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [15:0] rx_word,
  output logic rx_done
);
  localparam logic [13:0] A_CTRL = PORT_ONE ? `SPU_P1_CONTROL : `SPU_P0_CONTROL;
  localparam logic [13:0] A_PER = PORT_ONE ? `SPU_P1_RX_PERIOD : `SPU_P0_RX_PERIOD;
  localparam logic [13:0] A_DIV = PORT_ONE ? `SPU_P1_BCLK_DIV : `SPU_P0_BCLK_DIV;

  spu_pkg::spu_state_t s;
  spu_pkg::spu_state_t n;
  spu_edge_if eif();
  logic [15:0] f_data;
  logic f_valid;
  logic [4:0] len;
  logic rx_seen;
  logic tx_seen;
  logic rx_alt;
  logic tx_alt;
  logic rx_int;
  logic tx_int;
  logic rx_every;
  logic tx_every;
  logic [15:0] tx_lj;
  logic tx_bound;
  logic tx_unfr;

  function automatic logic [15:0] spu_mask(input logic [4:0] nb);
    spu_mask = 16'hFFFF >> (5'h10 - nb);
  endfunction

  spu_bitclk u_bclk (
    .mclk(mclk),
    .reset(reset),
    .internal(s.ctrl[`SPU_BCLK_INT]),
    .divider(s.sdiv),
    .pin_i(bclk_i),
    .edges(eif.src)
  );

  spu_fifo #(
    .W(`SPU_WORD_W),
    .DEPTH(`SPU_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .in_data(tx_word),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(~s.tx_full)
  );

  assign len = {1'b0, s.ctrl[`SPU_LEN_HI:`SPU_LEN_LO]} + 5'h01;
  assign rx_alt = s.ctrl[`SPU_RX_LATE];
  assign tx_alt = s.ctrl[`SPU_TX_LATE];
  assign rx_int = s.ctrl[`SPU_RX_INT];
  assign tx_int = s.ctrl[`SPU_TX_INT];
  assign rx_every = s.ctrl[`SPU_RX_EVERY];
  assign tx_every = s.ctrl[`SPU_TX_EVERY];
  // Sampled sync levels, polarity folded in
  assign rx_seen = rx_int ? (s.rx_gw != 5'h00) : (s.rfs_s2 ^ s.ctrl[`SPU_RX_LOW]);
  assign tx_seen = tx_int ? (s.tx_gw != 5'h00) : (s.tfs_s2 ^ s.ctrl[`SPU_TX_LOW]);
  assign tx_lj = s.tx_hold << (5'h10 - len);
  assign tx_bound = (s.tx_st == spu_pkg::SPU_IDLE) || (s.tx_cnt == 5'h00);
  assign tx_unfr = ~tx_every & s.tx_run;

  always_comb begin
    n = s;
    n.rx_done = 1'b0;
    n.rfs_s1 = rx_frame_sync_i;
    n.rfs_s2 = s.rfs_s1;
    n.tfs_s1 = tx_frame_sync_i;
    n.tfs_s2 = s.tfs_s1;
    n.din_s1 = serial_in_pin;
    n.din_s2 = s.din_s1;
    // Register port
    if (dm_wr) begin
      case (dm_addr)
        A_CTRL: n.ctrl = dm_wdata;
        A_PER: n.rxper = dm_wdata;
        A_DIV: n.sdiv = dm_wdata;
        default: ;
      endcase
    end
    if (dm_rd) begin
      case (dm_addr)
        A_CTRL: n.rdata = s.ctrl;
        A_PER: n.rdata = s.rxper;
        A_DIV: n.rdata = s.sdiv;
        default: n.rdata = 16'h0000;
      endcase
    end
    // Holding register fill
    if (!s.tx_full && f_valid) begin
      n.tx_hold = f_data & spu_mask(len);
      n.tx_full = 1'b1;
    end
    // Periodic rx sync, any bit clock source
    if (!rx_int) begin
      n.rx_gcnt = 16'h0000;
      n.rx_gw = 5'h00;
    end else if (eif.rise) begin
      if (s.rx_gcnt == 16'h0000) begin
        n.rx_gcnt = s.rxper;
        n.rx_gw = rx_alt ? len : 5'h01;
      end else begin
        n.rx_gcnt = s.rx_gcnt - 16'h0001;
        if (s.rx_gw != 5'h00) begin
          n.rx_gw = s.rx_gw - 5'h01;
        end
      end
    end
    // Receive on falling edges
    if (eif.fall) begin
      case (s.rx_st)
        spu_pkg::SPU_IDLE: begin
          if (rx_seen) begin
            n.rx_run = 1'b1;
            n.rx_st = spu_pkg::SPU_SHIFT;
            if (rx_alt) begin
              n.rx_sh = {s.rx_sh[14:0], s.din_s2};
              n.rx_cnt = len - 5'h01;
            end else begin
              n.rx_cnt = len;
            end
          end
        end
        spu_pkg::SPU_SHIFT: begin
          n.rx_sh = {s.rx_sh[14:0], s.din_s2};
          n.rx_cnt = s.rx_cnt - 5'h01;
          if (s.rx_cnt == 5'h01) begin
            n.rx_hold = {s.rx_sh[14:0], s.din_s2} & spu_mask(len);
            n.rx_done = 1'b1;
            if (!rx_every) begin
              n.rx_cnt = len;
            end else if (!rx_alt && rx_seen) begin
              n.rx_cnt = len;
            end else begin
              n.rx_st = spu_pkg::SPU_IDLE;
            end
          end
        end
        default: n.rx_st = spu_pkg::SPU_IDLE;
      endcase
    end
    // Transmit: drive on rising edges
    if (eif.rise) begin
      if (s.tx_st == spu_pkg::SPU_SHIFT && s.tx_cnt != 5'h00) begin
        n.dout = s.tx_sh[15];
        n.tx_sh = {s.tx_sh[14:0], 1'b0};
        n.tx_cnt = s.tx_cnt - 5'h01;
      end
      if (s.tx_gw != 5'h00) begin
        n.tx_gw = s.tx_gw - 5'h01;
      end
      if (tx_alt) begin
        if (s.tx_full && tx_bound && (tx_int || tx_unfr)) begin
          n.dout = tx_lj[15];
          n.tx_sh = {tx_lj[14:0], 1'b0};
          n.tx_cnt = len - 5'h01;
          n.tx_st = spu_pkg::SPU_SHIFT;
          n.tx_full = 1'b0;
          n.tx_run = 1'b1;
          if (tx_int && !tx_unfr) begin
            n.tx_gw = len;
          end
        end
      end else if (tx_int && s.tx_full && !tx_unfr &&
                   (s.tx_st == spu_pkg::SPU_IDLE || s.tx_cnt == 5'h01)) begin
        n.tx_gw = 5'h01;
      end
    end
    // Transmit: sync checks on falling edges
    if (eif.fall) begin
      if (!tx_alt && s.tx_full && tx_bound && (tx_unfr || tx_seen)) begin
        n.tx_sh = tx_lj;
        n.tx_cnt = len;
        n.tx_st = spu_pkg::SPU_SHIFT;
        n.tx_full = 1'b0;
        n.tx_run = 1'b1;
      end else if (tx_alt && !tx_int && !tx_unfr && s.tx_full && tx_bound && tx_seen) begin
        n.dout = tx_lj[15];
        n.tx_sh = {tx_lj[14:0], 1'b0};
        n.tx_cnt = len - 5'h01;
        n.tx_st = spu_pkg::SPU_SHIFT;
        n.tx_full = 1'b0;
        n.tx_run = 1'b1;
      end else if (s.tx_st == spu_pkg::SPU_SHIFT && s.tx_cnt == 5'h00) begin
        n.tx_st = spu_pkg::SPU_IDLE;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
      s.ctrl <= `SPU_CONTROL_RST;
      s.rxper <= `SPU_PERIOD_RST;
      s.sdiv <= `SPU_DIV_RST;
      s.rx_st <= spu_pkg::SPU_IDLE;
      s.tx_st <= spu_pkg::SPU_IDLE;
    end else begin
      s <= n;
    end
  end

  assign dm_rdata = s.rdata;
  assign bclk_o = eif.lvl;
  assign bclk_oe = s.ctrl[`SPU_BCLK_INT];
  assign rx_frame_sync_oe = rx_int;
  assign rx_frame_sync_o = rx_int & ((s.rx_gw != 5'h00) ^ s.ctrl[`SPU_RX_LOW]);
  assign tx_frame_sync_oe = tx_int;
  assign tx_frame_sync_o = tx_int & ((s.tx_gw != 5'h00) ^ s.ctrl[`SPU_TX_LOW]);
  assign serial_out_pin = s.dout;
  assign rx_word = s.rx_hold;
  assign rx_done = s.rx_done;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_tx_ext_start;
    (s.tx_st == spu_pkg::SPU_IDLE && !tx_int && tx_every) ##1 (s.tx_st == spu_pkg::SPU_SHIFT);
  endsequence
  sequence s_rx_norm_start;
    eif.fall && s.rx_st == spu_pkg::SPU_IDLE && rx_seen && !rx_alt;
  endsequence

  a_rx_right_just: assert property (rx_done |-> (rx_word & ~spu_mask(len)) == 16'h0000)
    else $error("received word not right-justified");
  a_rx_fall_only: assert property (!eif.fall |=> $stable(s.rx_st))
    else $error("receive state moved off a falling edge");
  a_rx_word_len: assert property (s_rx_norm_start |=> s.rx_cnt == len)
    else $error("word length count wrong");
  a_tx_wait_sync: assert property (s_tx_ext_start |-> $past(eif.fall) && $past(tx_seen))
    else $error("transmit started without sync");
  a_tx_sync_data: assert property ($rose(s.tx_gw != 5'h00) |-> $past(s.tx_full))
    else $error("internal tx sync without loaded word");
  a_rx_sync_period: assert property (eif.rise && rx_int && s.rx_gcnt == 16'h0000 |=> s.rx_gcnt == $past(s.rxper))
    else $error("rx sync period reload wrong");
  a_rx_sync_ignore: assert property (eif.fall && s.rx_st == spu_pkg::SPU_SHIFT && s.rx_cnt > 5'h01 |=> s.rx_st == spu_pkg::SPU_SHIFT)
    else $error("word cut short by sync");
  a_alt_sync_width: assert property (eif.rise && rx_int && rx_alt && s.rx_gcnt == 16'h0000 |=> s.rx_gw == len)
    else $error("late sync width not a word");
  a_rx_done_edge: assert property (rx_done |-> $past(eif.fall) && $past(s.rx_cnt) == 5'h01)
    else $error("completion not on last bit");
endmodule

// File: logic/spu_map.svh
// Address map, field positions, reset values and sizes of the serial port unit.
// Assumes inclusion by bare name from the framer and the bench modules.
`ifndef SPU_MAP_SVH
`define SPU_MAP_SVH
`define SPU_P1_RX_PERIOD 14'h3FF0
`define SPU_P1_BCLK_DIV 14'h3FF1
`define SPU_P1_CONTROL 14'h3FF2
`define SPU_P0_RX_PERIOD 14'h3FF4
`define SPU_P0_BCLK_DIV 14'h3FF5
`define SPU_P0_CONTROL 14'h3FF6
`define SPU_LEN_HI 3
`define SPU_LEN_LO 0
`define SPU_RX_LOW 6
`define SPU_TX_LOW 7
`define SPU_RX_INT 8
`define SPU_TX_INT 9
`define SPU_TX_LATE 10
`define SPU_TX_EVERY 11
`define SPU_RX_LATE 12
`define SPU_RX_EVERY 13
`define SPU_BCLK_INT 14
`define SPU_CONTROL_RST 16'h0000
`define SPU_PERIOD_RST 16'h0000
`define SPU_DIV_RST 16'h0000
`define SPU_WORD_W 16
`define SPU_FIFO_DEPTH 16
`endif

// File: logic/spu_pkg.sv
// Types of the serial port unit.
// Assumes the map header is on the include path.
package spu_pkg;
  typedef enum logic [1:0] {
    SPU_IDLE = 2'b01,
    SPU_SHIFT = 2'b10
  } spu_dir_st_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] rxper;
    logic [15:0] sdiv;
    logic [15:0] rdata;
    logic rfs_s1;
    logic rfs_s2;
    logic tfs_s1;
    logic tfs_s2;
    logic din_s1;
    logic din_s2;
    spu_dir_st_t rx_st;
    logic [15:0] rx_sh;
    logic [4:0] rx_cnt;
    logic rx_run;
    logic [15:0] rx_hold;
    logic rx_done;
    logic [15:0] rx_gcnt;
    logic [4:0] rx_gw;
    spu_dir_st_t tx_st;
    logic [15:0] tx_sh;
    logic [4:0] tx_cnt;
    logic tx_run;
    logic [15:0] tx_hold;
    logic tx_full;
    logic [4:0] tx_gw;
    logic dout;
  } spu_state_t;
endpackage

// File: logic/spu_edge_if.sv
// Bit clock level and edge enables passed from the bit clock source (divider or synchronised pin) to the framer.
// Assumes both ends run on mclk.
`timescale 1ns/100ps
interface spu_edge_if;
  logic lvl;
  logic rise;
  logic fall;
  modport src(output lvl, rise, fall);
  modport dst(input lvl, rise, fall);
endinterface

// File: logic/spu_bitclk.sv
// Bit clock source: internal divider or synchronised external pin, as edge enables.
// Assumes mclk is the core clock.
`timescale 1ns/100ps
module spu_bitclk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic internal,
  input wire logic [15:0] divider,
  input wire logic pin_i,
  spu_edge_if.src edges
);
  typedef struct packed {
    logic [15:0] cnt;
    logic lvl;
    logic s1;
    logic s2;
    logic s3;
    logic rise;
    logic fall;
  } spu_bclk_t;
  spu_bclk_t s;
  spu_bclk_t n;

  always_comb begin
    n = s;
    n.rise = 1'b0;
    n.fall = 1'b0;
    n.s1 = pin_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
    if (internal) begin
      // Toggle every divider+1 cycles: period 2*(divider+1)
      if (s.cnt == divider) begin
        n.cnt = 16'h0000;
        n.lvl = ~s.lvl;
        n.rise = ~s.lvl;
        n.fall = s.lvl;
      end else begin
        n.cnt = s.cnt + 16'h0001;
      end
    end else begin
      n.cnt = 16'h0000;
      n.lvl = s.s2;
      n.rise = s.s2 & ~s.s3;
      n.fall = ~s.s2 & s.s3;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign edges.lvl = s.lvl;
  assign edges.rise = s.rise;
  assign edges.fall = s.fall;
endmodule

// File: logic/spu_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a power-of-two depth.
`timescale 1ns/100ps
module spu_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } spu_fifo_t;
  spu_fifo_t s;
  spu_fifo_t n;
  logic push;
  logic pop;

  assign in_ready = s.cnt != (AW+1)'(DEPTH);
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data;
      n.wp = s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = s.rp + 1'b1;
    end
    case ({push, pop})
      2'b10: n.cnt = s.cnt + 1'b1;
      2'b01: n.cnt = s.cnt - 1'b1;
      default: n.cnt = s.cnt;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

// File: test/spu_codec_model.sv
// Far-side codec model: bit clock, active-high frame syncs, data pins.
// Assumes the bench starts the clock and calls one task at a time.
`timescale 1ns/100ps
module spu_codec_model #(
  parameter int HALF = 320
) (
  output logic bclk,
  output logic rx_sync,
  output logic tx_sync,
  output logic dr,
  input wire logic dt
);
  logic run;
  initial begin
    run = 1'b0;
    bclk = 1'b0;
    rx_sync = 1'b0;
    tx_sync = 1'b0;
    dr = 1'b0;
    forever begin
      #(HALF);
      bclk = run ? ~bclk : 1'b0;
    end
  end
  // Sync one bit ahead of the first data bit
  task automatic rx_start();
    @(posedge bclk);
    rx_sync = 1'b1;
  endtask
  // Data MSB first on rising edges
  task automatic rx_bits(input logic [15:0] w, input int len, input bit more);
    for (int i = len - 1; i >= 0; i--) begin
      @(posedge bclk);
      dr = w[i];
      rx_sync = more && (i == 0);
    end
    if (!more) begin
      @(posedge bclk);
      dr = ~dr;
    end
  endtask
  // Late framing: sync stands with the first bit only
  task automatic rx_late(input logic [15:0] w, input int len);
    for (int i = len - 1; i >= 0; i--) begin
      @(posedge bclk);
      dr = w[i];
      rx_sync = (i == len - 1);
    end
  endtask
  // Sync, then capture on falling edges
  task automatic tx_take(input int len, output logic [15:0] cap);
    cap = 16'h0000;
    @(posedge bclk);
    tx_sync = 1'b1;
    @(posedge bclk);
    tx_sync = 1'b0;
    repeat (len) begin
      @(negedge bclk);
      cap = {cap[14:0], dt};
    end
  endtask
endmodule

// File: test/tb_top.sv
// Bench of the framer: register port, stream ports, codec model on the pins.
// Assumes port 0 addresses.
`timescale 1ns/100ps
`include "spu_map.svh"
module tb_top;
  logic mclk;
  logic reset;
  logic [13:0] dm_addr;
  logic [15:0] dm_wdata;
  logic dm_wr;
  logic dm_rd;
  logic [15:0] dm_rdata;
  logic bclk_o, bclk_oe, rfs_o, rfs_oe, tfs_o, tfs_oe, dout;
  logic [15:0] tx_word;
  logic tx_valid;
  logic tx_ready;
  logic [15:0] rx_word;
  logic rx_done;
  logic m_bclk, m_rfs, m_tfs, m_dr;
  logic [15:0] d, cap, mask;
  int n_mismatch;
  int samples_checked;
  int k, n, len, cnt;
  int lens[3] = '{3, 8, 16};

  spu_framer #(.PORT_ONE(1'b0)) u_spu_framer (
    .mclk(mclk), .reset(reset), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_wr(dm_wr),
    .dm_rd(dm_rd), .dm_rdata(dm_rdata), .bclk_i(bclk_oe ? bclk_o : m_bclk), .bclk_o(bclk_o),
    .bclk_oe(bclk_oe), .rx_frame_sync_i(rfs_oe ? rfs_o : m_rfs), .rx_frame_sync_o(rfs_o),
    .rx_frame_sync_oe(rfs_oe), .tx_frame_sync_i(tfs_oe ? tfs_o : m_tfs), .tx_frame_sync_o(tfs_o),
    .tx_frame_sync_oe(tfs_oe), .serial_in_pin(m_dr), .serial_out_pin(dout), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_done(rx_done)
  );
  spu_codec_model u_spu_codec_model (
    .bclk(m_bclk), .rx_sync(m_rfs), .tx_sync(m_tfs), .dr(m_dr), .dt(dout)
  );

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_count(input int got, input int exp, input string what);
    samples_checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [13:0] a, input logic [15:0] v);
    dm_addr <= a;
    dm_wdata <= v;
    dm_wr <= 1'b1;
    @(posedge mclk);
    dm_wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic reg_rd(input logic [13:0] a, output logic [15:0] v);
    dm_addr <= a;
    dm_rd <= 1'b1;
    @(posedge mclk);
    dm_rd <= 1'b0;
    @(posedge mclk);
    v = dm_rdata;
  endtask

  // Bounded wait for a receive completion pulse
  task automatic wait_done();
    int t;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
      if (t > 3000) begin
        n_mismatch++;
        $display("MISMATCH %0t no receive completion", $time);
        final_report();
      end
    end while (rx_done !== 1'b1);
  endtask

  // Wait for the driven transmit sync, then capture on falling edges
  task automatic tx_follow(input int nb, output logic [15:0] c);
    int t;
    c = 16'h0000;
    t = 0;
    do begin
      @(negedge m_bclk);
      t++;
    end while (tfs_o !== 1'b1 && t < 40);
    if (tfs_o !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t no transmit sync", $time);
      final_report();
    end
    repeat (nb) begin
      @(negedge m_bclk);
      c = {c[14:0], dout};
    end
  endtask

  // Distance between two rises: bit clock in mclk, or low sync in bit clocks
  task automatic gap(input int sel, output int c);
    logic p, v;
    int first;
    first = -1;
    c = 0;
    p = 1'b1;
    for (int i = 0; i < 60; i++) begin
      if (sel == 0) @(posedge mclk);
      else @(negedge m_bclk);
      v = (sel == 0) ? bclk_o : ~rfs_o;
      if (v === 1'b1 && p === 1'b0) begin
        if (first < 0) first = i;
        else if (c == 0) c = i - first;
      end
      p = v;
    end
    @(posedge mclk);
  endtask

  initial begin
    reset = 1'b1;
    dm_addr = 14'h0000;
    dm_wdata = 16'h0000;
    dm_wr = 1'b0;
    dm_rd = 1'b0;
    tx_word = 16'h0000;
    tx_valid = 1'b0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    // Reset values, read-back, unmapped place
    reg_rd(`SPU_P0_CONTROL, d);
    chk_word(d, `SPU_CONTROL_RST, "control");
    chk_word({13'h0000, bclk_oe, rfs_oe, tfs_oe}, 16'h0000, "enables");
    reg_rd(`SPU_P0_RX_PERIOD, d);
    chk_word(d, `SPU_PERIOD_RST, "period");
    reg_rd(`SPU_P0_BCLK_DIV, d);
    chk_word(d, `SPU_DIV_RST, "divider");
    reg_wr(14'h3FF3, 16'hFFFF);
    reg_rd(14'h3FF3, d);
    chk_word(d, 16'h0000, "unmapped");
    reg_wr(`SPU_P0_RX_PERIOD, 16'h1234);
    reg_rd(`SPU_P0_RX_PERIOD, d);
    chk_word(d, 16'h1234, "period rw");
    // Internal bit clock
    reg_wr(`SPU_P0_BCLK_DIV, 16'h0003);
    reg_wr(`SPU_P0_CONTROL, 16'h4000);
    chk_word({15'h0000, bclk_oe}, 16'h0001, "clock drive");
    gap(0, cnt);
    chk_count(cnt, 2 * (3 + 1), "clock period");
    // External clock, framed continuous receive at several lengths
    u_spu_codec_model.run = 1'b1;
    foreach (lens[i]) begin
      len = lens[i];
      mask = 16'hFFFF >> (16 - len);
      reg_wr(`SPU_P0_CONTROL, 16'h2000 | 16'(len - 1));
      fork
        begin
          u_spu_codec_model.rx_start();
          u_spu_codec_model.rx_bits(16'hA5C3, len, 1'b1);
          u_spu_codec_model.rx_bits(16'h3C5A, len, 1'b0);
        end
        begin
          wait_done();
          chk_word(rx_word, 16'hA5C3 & mask, "rx first");
          wait_done();
          chk_word(rx_word, 16'h3C5A & mask, "rx next");
        end
      join
    end
    // Late framing on an external sync
    reg_wr(`SPU_P0_CONTROL, 16'h3007);
    fork
      u_spu_codec_model.rx_late(16'h1E69, 8);
      begin
        wait_done();
        chk_word(rx_word, 16'h0069, "rx late");
      end
    join
    // Unframed: one sync, later sync ignored, words back to back
    reg_wr(`SPU_P0_CONTROL, 16'h0007);
    fork
      begin
        u_spu_codec_model.rx_start();
        u_spu_codec_model.rx_bits(16'hA5C3, 8, 1'b1);
        u_spu_codec_model.rx_bits(16'h3C5A, 8, 1'b0);
      end
      begin
        wait_done();
        chk_word(rx_word, 16'h00C3, "rx unframed first");
        wait_done();
        chk_word(rx_word, 16'h005A, "rx unframed next");
      end
    join
    // Internal low-active receive sync on an external clock
    reg_wr(`SPU_P0_RX_PERIOD, 16'h0007);
    reg_wr(`SPU_P0_CONTROL, 16'h2147);
    chk_word({15'h0000, rfs_oe}, 16'h0001, "sync drive");
    gap(1, cnt);
    chk_count(cnt, 7 + 1, "sync period");
    // Late framing internal sync stands a whole 4-bit word
    reg_wr(`SPU_P0_CONTROL, 16'h3143);
    gap(1, cnt);
    chk_count(cnt, 7 + 1, "late sync period");
    cnt = 0;
    repeat (16) begin
      @(negedge m_bclk);
      if (rfs_o === 1'b0) cnt++;
    end
    chk_count(cnt, 2 * 4, "late sync width");
    // Fill while no transmit sync comes, then drain word by word
    reg_wr(`SPU_P0_CONTROL, 16'h0807);
    n = 0;
    tx_word <= {8'hF0, 8'hA0};
    tx_valid <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (tx_ready !== 1'b1) break;
      n++;
      tx_word <= {8'hF0, 8'hA0 + 8'(n)};
    end
    tx_valid <= 1'b0;
    chk_count(n, `SPU_FIFO_DEPTH + 1, "words taken");
    for (k = 0; k < n; k++) begin
      u_spu_codec_model.tx_take(8, cap);
      chk_word(cap, {8'h00, 8'hA0 + 8'(k)}, "tx word");
    end
    @(posedge mclk);
    chk_word({15'h0000, tx_ready}, 16'h0001, "drained");
    // Internal transmit sync follows a loaded word
    reg_wr(`SPU_P0_CONTROL, 16'h0A07);
    tx_word <= 16'h5A3C;
    tx_valid <= 1'b1;
    @(posedge mclk);
    tx_valid <= 1'b0;
    tx_follow(8, cap);
    chk_word(cap, 16'h003C, "tx own sync");
    final_report();
  end
endmodule
